//--- rtl/xfer_mode_decode.sv
/*
  Transfer controller mode-field decoder with an APB register port.
  Software writes the transfer information mode word, then activates.
  Assumes the APB master keeps the request stable until pready.
*/
// The placing of the registers and the APB interface to the registers were left to the implementer.
// Overview of operation
// R1: Mode field 00 normal, 01 repeat, 10 block; 11 reserved.
// R2: Size field 00 byte, 01 word, 10 longword; 11 reserved.
// R3: Repeat/block with side bit 0: destination is the area.
// R4: Repeat/block with side bit 1: source is the area.
// R5: Chain bit 0: end transfer, wait for next activation.
// R6: Chain bit 1: fetch next info sixteen bytes on, same source.
// R7: Normal mode ignores the area-side select bit.
module xfer_mode_decode (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output xfer_mode_pkg::xfer_mode_t mode_out,
  output xfer_mode_pkg::xfer_size_t size_out,
  output logic                      dst_area,
  output logic                      src_area,
  output logic                      info_fetch,
  output logic      [31:0]          info_addr,
  output logic                      busy,
  output logic                      done
);
  import xfer_mode_pkg::*;

  logic [31:0] mode_q, mode_d;
  logic [31:0] base_q, base_d;
  logic [31:0] rdata_q, rdata_d;
  logic        rdy_q, rdy_d, err_q, err_d;
  ctl_state_t  state_q, state_d;
  xfer_mode_t  mode_q2, mode_d2;
  xfer_size_t  size_q, size_d;
  logic        dst_q, dst_d, src_q, src_d;
  logic        fetch_q, fetch_d, done_q, done_d;
  logic [31:0] iaddr_q, iaddr_d;
  logic        resv_q, resv_d;
  logic        busy_q, busy_d;

  logic        acc, wr, rd;
  xfer_mode_t  fmode;
  xfer_size_t  fsize;
  logic        fside, fchain, area_on;

  assign acc     = psel && penable && !rdy_q;
  assign wr      = acc && pwrite;
  assign rd      = acc && !pwrite;
  assign fmode   = xfer_mode_t'(mode_q[mode_lo_pos+1:mode_lo_pos]); // R1
  assign fsize   = xfer_size_t'(mode_q[size_lo_pos+1:size_lo_pos]); // R2
  assign fside   = mode_q[side_pos];
  assign fchain  = mode_q[chain_pos];
  // Only repeat and block have an area, so normal drops the side bit
  assign area_on = (fmode == xm_repeat) || (fmode == xm_block); // R7

  // Register map, one aligned word each:
  //   mode word   - mode, size, area side and chain fields
  //   activation  - start address; a write while idle starts a run
  //   status      - busy, dst, src, fetch, done, reserved-code seen
  //   next info   - address of the set being worked on
  // Writes to status and next info are dropped without an error, so
  // software may write back a word that it has just read
  always_comb begin
    mode_d  = mode_q;
    base_d  = base_q;
    rdy_d   = acc;
    err_d   = 1'b0;
    rdata_d = rdata_q;
    if (wr) begin
      unique case (paddr)
        off_mode: mode_d = pwdata;
        off_cmd:  base_d = {pwdata[31:4], 4'h0};
        default:  err_d  = (paddr != off_stat) && (paddr != off_next);
      endcase
    end
    if (rd) begin
      unique case (paddr)
        off_mode: rdata_d = mode_q;
        off_cmd:  rdata_d = base_q;
        off_stat: rdata_d = {26'h000_0000, resv_q, done_q, fetch_q,
                             src_q, dst_q, state_q != st_wait};
        off_next: rdata_d = iaddr_q;
        default: begin
          rdata_d = 32'h0000_0000;
          err_d   = 1'b1;
        end
      endcase
    end
  end

  // Writing the activation word starts a run; a busy engine ignores it
  always_comb begin
    state_d = state_q;
    mode_d2 = mode_q2;
    size_d  = size_q;
    dst_d   = dst_q;
    src_d   = src_q;
    fetch_d = 1'b0;
    done_d  = 1'b0;
    iaddr_d = iaddr_q;
    resv_d  = resv_q;
    unique case (state_q)
      st_wait: begin
        if (wr && paddr == off_cmd) begin
          state_d = st_run;
          iaddr_d = {pwdata[31:4], 4'h0};
          fetch_d = 1'b1;
        end
      end
      st_run: begin
        mode_d2 = fmode;
        size_d  = fsize;
        resv_d  = (fmode == xm_resv) || (fsize == xs_resv);
        dst_d   = area_on && !fside; // R3
        src_d   = area_on && fside;  // R4
        if (fchain) begin
          state_d = st_chain; // R6
        end else begin
          state_d = st_wait; // R5
          done_d  = 1'b1;
        end
      end
      st_chain: begin
        iaddr_d = iaddr_q + info_stride; // R6
        fetch_d = 1'b1;
        state_d = st_run;
      end
      default: state_d = st_wait;
    endcase
    busy_d  = (state_d != st_wait);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q  <= mode_reset;
      base_q  <= addr_reset;
      rdata_q <= 32'h0000_0000;
      rdy_q   <= 1'b0;
      err_q   <= 1'b0;
      state_q <= st_wait;
      mode_q2 <= xm_normal;
      size_q  <= xs_byte;
      dst_q   <= 1'b0;
      src_q   <= 1'b0;
      fetch_q <= 1'b0;
      done_q  <= 1'b0;
      iaddr_q <= addr_reset;
      resv_q  <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      mode_q  <= mode_d;
      base_q  <= base_d;
      rdata_q <= rdata_d;
      rdy_q   <= rdy_d;
      err_q   <= err_d;
      state_q <= state_d;
      mode_q2 <= mode_d2;
      size_q  <= size_d;
      dst_q   <= dst_d;
      src_q   <= src_d;
      fetch_q <= fetch_d;
      done_q  <= done_d;
      iaddr_q <= iaddr_d;
      resv_q  <= resv_d;
      busy_q  <= busy_d;
    end
  end

  assign prdata     = rdata_q;
  assign pready     = rdy_q;
  assign pslverr    = err_q;
  assign mode_out   = mode_q2;
  assign size_out   = size_q;
  assign dst_area   = dst_q;
  assign src_area   = src_q;
  assign info_fetch = fetch_q;
  assign info_addr  = iaddr_q;
  assign busy       = busy_q;
  assign done       = done_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_mode_decode: assert property ( // R1
    $past(state_q == st_run) |-> mode_out == $past(fmode))
    else $error("mode output not decoded from field");
  chk_size_decode: assert property ( // R2
    $past(state_q == st_run) |-> size_out == $past(fsize))
    else $error("size output not decoded from field");
  chk_dst_area: assert property ( // R3
    state_q == st_run && area_on && !fside |=> dst_area && !src_area)
    else $error("destination area not selected");
  chk_src_area: assert property ( // R4
    state_q == st_run && area_on && fside |=> src_area && !dst_area)
    else $error("source area not selected");
  chk_chain_end: assert property ( // R5
    state_q == st_run && !fchain |=> done && state_q == st_wait)
    else $error("unchained run did not end");
  chk_chain_next: assert property ( // R6
    state_q == st_run && fchain |=> ##1 info_fetch
      && info_addr == $past(info_addr, 2) + info_stride)
    else $error("chained fetch not sixteen bytes on");
  chk_normal_side: assert property ( // R7
    state_q == st_run && fmode == xm_normal |=> !dst_area && !src_area)
    else $error("normal mode used area side");
  chk_apb_ready: assert property (
    psel && penable && !pready |=> pready)
    else $error("apb answer late");

  chk_apb_pulse: assert property (
    pready |=> !pready)
    else $error("apb ready held too long");

  chk_err_ready: assert property (
    pslverr |-> pready)
    else $error("error without ready");

  chk_ready_req: assert property (
    pready |-> $past(psel && penable))
    else $error("ready without a request");

  chk_mode_write: assert property (
    acc && pwrite && paddr == off_mode |=> mode_q == $past(pwdata))
    else $error("mode word write lost");

  chk_cmd_base: assert property (
    acc && pwrite && paddr == off_cmd
      |=> base_q == {$past(pwdata[31:4]), 4'h0})
    else $error("activation base not stored");

  chk_stat_ro: assert property (
    acc && pwrite && (paddr == off_stat || paddr == off_next)
      |=> mode_q == $past(mode_q) && base_q == $past(base_q) && !pslverr)
    else $error("read-only word changed state");

  chk_unmapped_rd: assert property (
    acc && !pwrite && paddr != off_mode && paddr != off_cmd
      && paddr != off_stat && paddr != off_next
      |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped read not refused");

  chk_start_idle: assert property (
    state_q == st_wait && acc && pwrite && paddr == off_cmd
      |=> busy && info_fetch && info_addr == {$past(pwdata[31:4]), 4'h0})
    else $error("activation did not start a run");

  chk_busy_ignore: assert property (
    state_q == st_run && acc && pwrite && paddr == off_cmd |=> !info_fetch)
    else $error("activation taken while busy");

  chk_wait_quiet: assert property ( // R5
    state_q == st_wait && !(acc && pwrite && paddr == off_cmd)
      |=> !info_fetch && !busy)
    else $error("idle engine woke without activation");

  chk_done_pulse: assert property ( // R5
    done |=> !done)
    else $error("done held too long");

  chk_done_idle: assert property ( // R5
    done |-> !busy)
    else $error("done while still busy");

  chk_run_once: assert property (
    state_q == st_run |=> state_q != st_run)
    else $error("run state held");

  chk_chain_run: assert property ( // R6
    state_q == st_chain |=> state_q == st_run && info_fetch)
    else $error("chain state did not fetch");

  chk_chain_busy: assert property ( // R6
    state_q == st_run && fchain |=> !done && busy)
    else $error("chained run ended early");

  chk_fetch_busy: assert property ( // R6
    info_fetch |-> busy)
    else $error("fetch while idle");

  chk_fetch_align: assert property ( // R6
    info_fetch |-> info_addr[3:0] == 4'h0)
    else $error("info address not on a set boundary");

  chk_resv_mode: assert property ( // R1
    state_q == st_run && fmode == xm_resv |=> resv_q)
    else $error("reserved mode not flagged");

  chk_resv_size: assert property ( // R2
    state_q == st_run && fsize == xs_resv |=> resv_q)
    else $error("reserved size not flagged");

  chk_area_excl: assert property ( // R4
    !(dst_area && src_area))
    else $error("both area sides selected");

  cov_chain:  cover property (state_q == st_chain);
  cov_block:  cover property (state_q == st_run && fmode == xm_block);
  cov_repeat: cover property (state_q == st_run && fmode == xm_repeat);
  cov_err:    cover property (pslverr);
  cov_start:  cover property (state_q == st_wait && state_d == st_run);
endmodule // xfer_mode_decode

//--- inc/xfer_mode_pkg.sv
/*
  Package for the transfer controller mode-field decoder: register map,
  field positions, encodings and reset values.
  Assumes a 32-bit APB slave with word-aligned registers.
*/
package xfer_mode_pkg;
  localparam logic [11:0] off_mode  = 12'h000;
  localparam logic [11:0] off_cmd   = 12'h004;
  localparam logic [11:0] off_stat  = 12'h008;
  localparam logic [11:0] off_next  = 12'h00C;

  localparam int mode_lo_pos  = 10;
  localparam int size_lo_pos  = 8;
  localparam int side_pos     = 7;
  localparam int chain_pos    = 6;

  localparam logic [31:0] mode_reset  = 32'h0000_0000;
  localparam logic [31:0] addr_reset  = 32'h0000_0000;
  localparam logic [31:0] info_stride = 32'h0000_0010;

  typedef enum logic [1:0] {
    xm_normal = 2'b00,
    xm_repeat = 2'b01,
    xm_block  = 2'b10,
    xm_resv   = 2'b11
  } xfer_mode_t;

  typedef enum logic [1:0] {
    xs_byte  = 2'b00,
    xs_word  = 2'b01,
    xs_long  = 2'b10,
    xs_resv  = 2'b11
  } xfer_size_t;

  typedef enum logic [1:0] {
    st_wait  = 2'b00,
    st_run   = 2'b01,
    st_chain = 2'b10
  } ctl_state_t;
endpackage

//--- dv/info_mem_model.sv
/*
  Far-side stand-in for the transfer information memory: counts fetches.
  Assumes info_fetch is a one-cycle pulse in the pclk domain.
*/
module info_mem_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        info_fetch,
  output logic      [31:0] fetch_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fetch_cnt <= 32'h0000_0000;
    else if (info_fetch) fetch_cnt <= fetch_cnt + 32'h0000_0001;
  end
endmodule // info_mem_model

//--- dv/transfer_controller_mode_fields_tb.sv
/*
  Self-checking bench for the mode-field decoder over APB.
  Assumes the one-wait-state APB slave and pulse outputs of the design.
*/
module transfer_controller_mode_fields_tb;
  import xfer_mode_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, info_addr, fetch_cnt, nxt, c0;
  xfer_mode_t mode_out;
  xfer_size_t size_out;
  logic dst_area, src_area, info_fetch, busy, done;
  logic [32:0] r;
  logic [5:0] note[$];
  int error_cnt, n_tests, seed;
  xfer_mode_decode i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_out(mode_out), .size_out(size_out), .dst_area(dst_area),
    .src_area(src_area), .info_fetch(info_fetch), .info_addr(info_addr),
    .busy(busy), .done(done));
  info_mem_model i_mem (.pclk(pclk), .presetn(presetn),
    .info_fetch(info_fetch), .fetch_cnt(fetch_cnt));
  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  task cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task cmp6(input logic [5:0] e, input logic [5:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value decode exp %b got %b", e, g);
    end
  endtask
  task test_done;
    $display("errors %0d compares %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Only the watchdog ends a wait for the answer
    do @(posedge pclk); while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel <= 0;
    penable <= 0;
  endtask
  // Area flags only make sense outside normal mode
  function automatic logic [5:0] ex(logic [4:0] f);
    return {f[4:1], f[4:3] != 2'b00 && !f[0], f[4:3] != 2'b00 && f[0]};
  endfunction
  task run(input logic [4:0] f, input logic ch);
    logic [31:0] b;
    b = $random(seed) & 32'hffff_fff0;
    apb(1, off_mode, {20'h0_0000, f, ch, 6'h00});
    nxt = b;
    note.push_back(ex(ch ? 5'b10000 : f));
    apb(1, off_cmd, b);
    // Chain keeps going until software clears the chain bit
    if (ch) apb(1, off_mode, {20'h0_0000, 5'b10000, 1'b0, 6'h00});
    do @(posedge pclk); while (busy !== 1'b0);
    apb(0, off_cmd, 32'h0000_0000);
    cmp32("base", b, r[31:0]);
  endtask
  always @(posedge pclk) begin
    if (info_fetch === 1'b1) begin
      cmp32("info_addr", nxt, info_addr);
      nxt = nxt + 32'h0000_0010;
    end
    if (done === 1'b1 && note.size() > 0)
      cmp6(note.pop_front(), {mode_out, size_out, dst_area, src_area});
  end
  initial begin
    #(50 * 20000);
    error_cnt++;
    test_done;
  end
  initial begin
    seed = 32'he54e_c5a0;
    presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 12'h000; pwdata = 32'h0000_0000;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    for (int m = 0; m < 3; m++)
      for (int s = 0; s < 3; s++)
        for (int d = 0; d < 2; d++)
          run({m[1:0], s[1:0], d[0]}, 1'b0);
    apb(0, off_stat, 32'h0000_0000);
    cmp32("status", 32'h0000_0004, r[31:0]);
    apb(0, off_next, 32'h0000_0000);
    cmp32("next", nxt - 32'h0000_0010, r[31:0]);
    c0 = fetch_cnt;
    run(5'b01101, 1'b1);
    cmp32("fetches", 32'h0000_0001, {31'h0, fetch_cnt - c0 >= 2});
    apb(0, 12'h010, 32'h0000_0000);
    cmp32("slverr", 32'h0000_0001, {31'h0, r[32]});
    cmp32("bad_rd", 32'h0000_0000, r[31:0]);
    repeat (4) @(posedge pclk);
    cmp32("left", 32'h0000_0000, note.size());
    test_done;
  end
endmodule // transfer_controller_mode_fields_tb
